// File: common/btu_pkg.sv
// breakpoint and trace unit: register map, field layout, encodings
// assumes a byte-addressed 8-bit register port with 32-bit data
package btu_pkg;
    localparam logic [7:0] A_CTRL    = 8'h00;
    localparam logic [7:0] A_CAUSE   = 8'h04;
    localparam logic [7:0] A_BP0     = 8'h10;
    localparam logic [7:0] BP_STRIDE = 8'h10;
    localparam logic [7:0] O_ADR     = 8'h04;
    localparam logic [7:0] O_DAT     = 8'h08;
    localparam logic [7:0] A_WIN     = 8'h30;
    localparam logic [7:0] A_TP0     = 8'h40;
    localparam logic [7:0] TP_STRIDE = 8'h08;
    localparam logic [7:0] A_TPTR    = 8'h50;
    localparam logic [7:0] A_TDAT    = 8'h54;
    localparam logic [7:0] A_MAP     = 8'h58;
    // control bits
    localparam int C_GO = 0, C_STOP = 1, C_TEN = 2, C_CLK = 3, C_RDY = 4, C_TON = 5;
    localparam logic RST_TEN = 1'b1;
    localparam logic RST_RDY = 1'b1;
    // breakpoint / tracepoint config fields
    localparam int F_EN = 0, F_EXE = 1, F_SEN = 2, F_SEG = 3, F_AM = 5, F_DEN = 7;
    localparam int F_STM = 8;
    localparam int W_BP = 12, W_VAL = 16, P_CNT = 16;
    localparam int M_KIND = 16;
    typedef enum logic [1:0] {AM_ONE = 2'h0, AM_WIN = 2'h1, AM_GE = 2'h2, AM_LE = 2'h3} btu_am_e;
    typedef enum logic [2:0] {
        CZ_NONE = 3'h0, CZ_BP0 = 3'h1, CZ_BP1 = 3'h2, CZ_EXT = 3'h3, CZ_GRD = 3'h4, CZ_SW = 3'h5
    } btu_cause_e;
    typedef enum logic [2:0] {
        BS_INTA = 3'h0, BS_IORD = 3'h1, BS_IOWR = 3'h2, BS_HALT = 3'h3,
        BS_FETCH = 3'h4, BS_MRD = 3'h5, BS_MWR = 3'h6, BS_PASS = 3'h7
    } btu_bs_e;
    typedef enum logic [1:0] {QS_NONE = 2'h0, QS_FIRST = 2'h1, QS_FLUSH = 2'h2, QS_NEXT = 2'h3} btu_qs_e;
    typedef enum logic [1:0] {MK_GUARD = 2'h0, MK_USER = 2'h1, MK_BORROW = 2'h2} btu_mk_e;
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_BRK = 2'h3} btu_st_e;
    typedef enum logic [1:0] {PO_OLD = 2'h0, PO_NEW = 2'h1, PO_FWD = 2'h2, PO_BACK = 2'h3} btu_po_e;
endpackage

// File: src/btu_top.sv
// breakpoint, tracepoint and trace buffer logic watching a target cpu's pins
// assumes target pins are synchronous to i_clk_sys (the emulated cpu clock)
//
// Contract
// R1: two independent breakpoint registers, each can stop emulation.
// R2: each breakpoint is either execution or bus-condition type.
// R3: execution break fires when a byte is executed, not prefetched.
// R4: bus condition combines address, status, data and segment qualifiers.
// R5: status qualifier is any set of bus cycle kinds.
// R6: segment qualifier matches only cycles using that segment.
// R7: address is single or any set in a 1024-byte even window.
// R8: unbounded mode halts on memory access at or above/below value.
// R9: falling edge of external break input stops emulation, once.
// R10: outside gear drives external break high then low.
// R11: a match output pulses when a break occurs.
// R12: two tracepoints start and stop trace collection.
// R13: one frame when address valid, one when data valid.
// R14: one frame each clock the instruction queue is active.
// R15: frame holds 20 address/data lines plus cpu status.
// R16: 1023-frame circular trace memory kept across runs.
// R17: global trace enable independent of tracepoints.
// R18: read pointer set oldest/newest or moved by a count.
// R19: cpu clock source selectable internal or target.
// R20: outside emulation nmi and reset ignored; grant and hold pass.
// R21: target ready can be enabled or disabled for borrowed memory.
// R22: cause code of most recent halt is readable.
// R23: capture runs from start match until stop match, if enabled.
// R24: all blocks start guarded; access to guarded block is an error.
`timescale 1ns/10ps
module btu_top
    import btu_pkg::*;
#(
    parameter int TRC_DEPTH = 1023,
    parameter int Q_DEPTH   = 6
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic [19:0] i_ad,
    input  wire logic        i_ale,
    input  wire logic        i_dv,
    input  wire logic [2:0]  i_stat,
    input  wire logic [1:0]  i_seg,
    input  wire logic [1:0]  i_qs,
    input  wire logic        i_brk_ext_n,
    input  wire logic        i_nmi,
    input  wire logic        i_reset,
    input  wire logic        i_rdy,
    input  wire logic        i_request_grant_line,
    input  wire logic        i_hold,
    output logic             o_emul,
    output logic             o_brk_match,
    output logic             o_clk_ext_sel,
    output logic             o_nmi,
    output logic             o_reset,
    output logic             o_rdy,
    output logic             o_request_grant_line,
    output logic             o_hold
);
    localparam int TW = 29;
    localparam logic [9:0] DMAX = 10'(TRC_DEPTH - 1);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    btu_st_e     st_r;
    btu_st_e     st_nxt;
    btu_cause_e  cause_r;
    logic        trc_en_r;
    logic        rdy_en_r;
    logic        trc_on_r;
    logic        ext_prev_r;
    logic [19:0] lat_ad_r;
    logic [2:0]  lat_st_r;
    logic [1:0]  lat_sg_r;
    logic [1:0]  lat_mk_r;
    logic [1:0]  map_r [1024];
    logic [1:0]  bp_hit;
    logic [1:0]  tp_hit;
    logic [15:0] bp_cfg [2];
    logic [19:0] bp_adr [2];
    logic [31:0] bp_dat [2];
    logic [19:0] tp_adr [2];
    logic [15:0] tp_cfg [2];
    logic [19:0] q_r [Q_DEPTH];
    logic [2:0]  q_cnt_r;
    logic [TW-1:0] trc_mem [TRC_DEPTH];
    logic [9:0]  wr_ptr_r;
    logic [9:0]  rd_ptr_r;
    logic [9:0]  t_cnt_r;
    logic [31:0] rd_val;
    logic        run;
    logic        go;
    logic        sw_stop;
    logic        ext_fall;
    logic        grd_hit;
    logic        brk;
    logic        cap;
    logic        push;
    logic        pop;
    logic        flush;

    function automatic logic is_mem(input logic [2:0] s);
        return s == BS_FETCH || s == BS_MRD || s == BS_MWR;
    endfunction

    function automatic logic [9:0] p_add(input logic [9:0] p, input logic [9:0] n);
        logic [10:0] s;
        s = {1'b0, p} + {1'b0, n};
        return (s >= 11'(TRC_DEPTH)) ? 10'(s - 11'(TRC_DEPTH)) : s[9:0];
    endfunction

    function automatic logic [9:0] p_sub(input logic [9:0] p, input logic [9:0] n);
        return (p >= n) ? p - n : 10'({1'b0, p} + 11'(TRC_DEPTH) - {1'b0, n});
    endfunction

    assign run      = st_r == ST_RUN;
    assign go       = i_wr && i_addr == A_CTRL && i_wdata[C_GO];
    assign sw_stop  = i_wr && i_addr == A_CTRL && i_wdata[C_STOP];
    assign ext_fall = ext_prev_r && !i_brk_ext_n; // R9
    assign grd_hit  = i_ale && is_mem(i_stat) && map_r[i_ad[19:10]] == MK_GUARD; // R24
    assign brk      = bp_hit != 2'h0 || ext_fall || grd_hit || sw_stop;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: if (go) st_nxt = ST_RUN;
            ST_RUN:  if (brk) st_nxt = ST_BRK; // R1
            ST_BRK:  st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_r        <= ST_IDLE;
            o_emul      <= 1'b0;
            o_brk_match <= 1'b0;
        end
        else
        begin
            st_r        <= st_nxt;
            o_emul      <= st_nxt == ST_RUN;
            o_brk_match <= st_nxt == ST_BRK; // R11
        end
    end

    // priority fixes one code when several causes hit in one clock
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            cause_r <= CZ_NONE;
        else if (st_r == ST_IDLE && go)
            cause_r <= CZ_NONE;
        else if (run && brk) // R22
        begin
            if (bp_hit[0])
                cause_r <= CZ_BP0;
            else if (bp_hit[1])
                cause_r <= CZ_BP1;
            else if (ext_fall)
                cause_r <= CZ_EXT;
            else if (grd_hit)
                cause_r <= CZ_GRD;
            else
                cause_r <= CZ_SW;
        end
    end

    // a held low level gives no second edge
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            ext_prev_r <= 1'b1;
        else
            ext_prev_r <= i_brk_ext_n; // R9
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            trc_en_r      <= RST_TEN;
            rdy_en_r      <= RST_RDY;
            o_clk_ext_sel <= 1'b0;
        end
        else if (i_wr && i_addr == A_CTRL)
        begin
            trc_en_r      <= i_wdata[C_TEN]; // R17
            rdy_en_r      <= i_wdata[C_RDY]; // R21
            o_clk_ext_sel <= i_wdata[C_CLK]; // R19
        end
    end

    // target pins pass through a flop each; nmi and reset only in emulation
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_nmi                <= 1'b0;
            o_reset              <= 1'b0;
            o_request_grant_line <= 1'b0;
            o_hold               <= 1'b0;
            o_rdy                <= 1'b0;
        end
        else
        begin
            o_nmi                <= run && i_nmi; // R20
            o_reset              <= run && i_reset; // R20
            o_request_grant_line <= i_request_grant_line; // R20
            o_hold               <= i_hold; // R20
            o_rdy                <= (lat_mk_r == MK_BORROW && !rdy_en_r) || i_rdy; // R21
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lat_ad_r <= 20'h0_0000;
            lat_st_r <= BS_PASS;
            lat_sg_r <= 2'h0;
            lat_mk_r <= MK_GUARD;
        end
        else if (i_ale)
        begin
            lat_ad_r <= i_ad;
            lat_st_r <= i_stat;
            lat_sg_r <= i_seg;
            lat_mk_r <= map_r[i_ad[19:10]];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < 1024; i++)
                map_r[i] <= MK_GUARD; // R24
        end
        else if (i_wr && i_addr == A_MAP)
            map_r[i_wdata[9:0]] <= i_wdata[M_KIND+:2];
    end

    // prefetch queue of fetched byte addresses; one byte per fetch cycle
    assign push  = i_dv && lat_st_r == BS_FETCH && q_cnt_r < 3'(Q_DEPTH);
    assign pop   = (i_qs == QS_FIRST || i_qs == QS_NEXT) && q_cnt_r != 3'h0;
    assign flush = i_qs == QS_FLUSH;

    always_ff @(posedge i_clk_sys)
    begin
        if (pop)
            for (int i = 0; i < Q_DEPTH - 1; i++)
                q_r[i] <= q_r[i+1];
        if (push)
            q_r[q_cnt_r - 3'(pop)] <= lat_ad_r;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            q_cnt_r <= 3'h0;
        else if (flush)
            q_cnt_r <= 3'h0;
        else
            q_cnt_r <= q_cnt_r + 3'(push) - 3'(pop);
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_bp
        logic [7:0]    base;
        logic [15:0]   cfg_r;
        logic [19:0]   adr_r;
        logic [31:0]   dat_r;
        logic [1023:0] win_r;
        logic [19:0]   off;
        logic          adr_ok;
        logic          nx_hit;
        logic          ex_hit;
        assign base = A_BP0 + 8'(g) * BP_STRIDE;
        always_ff @(posedge i_clk_sys or negedge i_rstn)
        begin
            if (!i_rstn)
            begin
                cfg_r <= 16'h0000;
                adr_r <= 20'h0_0000;
                dat_r <= 32'h0000_0000;
                win_r <= '0;
            end
            else if (i_wr)
            begin
                if (i_addr == base)
                    cfg_r <= i_wdata[15:0]; // R2
                if (i_addr == base + O_ADR)
                    adr_r <= i_wdata[19:0];
                if (i_addr == base + O_DAT)
                    dat_r <= i_wdata;
                if (i_addr == A_WIN && i_wdata[W_BP] == 1'(g))
                    win_r[i_wdata[9:0]] <= i_wdata[W_VAL]; // R7
            end
        end
        assign off = lat_ad_r - {adr_r[19:1], 1'b0};
        always_comb
        begin
            case (btu_am_e'(cfg_r[F_AM+:2]))
                AM_ONE:  adr_ok = lat_ad_r == adr_r; // R7
                AM_WIN:  adr_ok = off[19:10] == 10'h000 && win_r[off[9:0]]; // R7
                AM_GE:   adr_ok = is_mem(lat_st_r) && lat_ad_r >= adr_r; // R8
                AM_LE:   adr_ok = is_mem(lat_st_r) && lat_ad_r <= adr_r; // R8
                default: adr_ok = 1'b0;
            endcase
        end
        // bus conditions resolve when data is valid on the lines
        assign nx_hit = cfg_r[F_EN] && !cfg_r[F_EXE] && i_dv && adr_ok // R4
            && cfg_r[F_STM + 32'(lat_st_r)] // R5
            && (!cfg_r[F_SEN] || lat_sg_r == cfg_r[F_SEG+:2]) // R6
            && (!cfg_r[F_DEN] || ((i_ad[15:0] ^ dat_r[15:0]) & dat_r[31:16]) == 16'h0000);
        assign ex_hit = cfg_r[F_EN] && cfg_r[F_EXE] && pop && q_r[0] == adr_r; // R3
        assign bp_hit[g] = nx_hit || ex_hit; // R1
        assign bp_cfg[g] = cfg_r;
        assign bp_adr[g] = adr_r;
        assign bp_dat[g] = dat_r;
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_tp
        logic [7:0]  base;
        logic [19:0] adr_r;
        logic [15:0] cfg_r;
        assign base = A_TP0 + 8'(g) * TP_STRIDE;
        always_ff @(posedge i_clk_sys or negedge i_rstn)
        begin
            if (!i_rstn)
            begin
                adr_r <= 20'h0_0000;
                cfg_r <= 16'h0000;
            end
            else if (i_wr && i_addr == base)
                adr_r <= i_wdata[19:0];
            else if (i_wr && i_addr == base + O_ADR)
                cfg_r <= i_wdata[15:0];
        end
        assign tp_hit[g] = i_ale && cfg_r[F_EN] && i_ad == adr_r // R12
            && cfg_r[F_STM + 32'(i_stat)];
        assign tp_adr[g] = adr_r;
        assign tp_cfg[g] = cfg_r;
    end

    // an unused start tracepoint means trace from the first cycle of a run
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            trc_on_r <= 1'b0;
        else if (st_r == ST_IDLE && go)
            trc_on_r <= !tp_cfg[0][F_EN]; // R23
        else if (run && tp_hit[1])
            trc_on_r <= 1'b0; // R23
        else if (run && tp_hit[0])
            trc_on_r <= 1'b1; // R23
    end

    assign cap = run && trc_en_r && trc_on_r // R17
        && (i_ale || i_dv || i_qs != QS_NONE); // R13 R14

    always_ff @(posedge i_clk_sys)
    begin
        if (cap)
            trc_mem[wr_ptr_r] <= {i_dv, i_ale, i_seg, i_qs, i_stat, i_ad}; // R15
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_ptr_r <= 10'h000;
            t_cnt_r  <= 10'h000;
        end
        else if (cap)
        begin
            wr_ptr_r <= (wr_ptr_r == DMAX) ? 10'h000 : wr_ptr_r + 10'h001; // R16
            if (t_cnt_r != DMAX + 10'h001)
                t_cnt_r <= t_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            rd_ptr_r <= 10'h000;
        else if (i_wr && i_addr == A_TPTR)
        begin
            case (btu_po_e'(i_wdata[1:0]))
                PO_OLD:  rd_ptr_r <= (t_cnt_r <= DMAX) ? 10'h000 : wr_ptr_r; // R18
                PO_NEW:  rd_ptr_r <= (t_cnt_r == 10'h000) ? 10'h000
                                   : p_sub(wr_ptr_r, 10'h001); // R18
                PO_FWD:  rd_ptr_r <= p_add(rd_ptr_r, i_wdata[P_CNT+:10]); // R18
                PO_BACK: rd_ptr_r <= p_sub(rd_ptr_r, i_wdata[P_CNT+:10]); // R18
                default: rd_ptr_r <= rd_ptr_r;
            endcase
        end
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (i_addr)
            A_CTRL:
            begin
                rd_val[C_GO]  = run;
                rd_val[C_TEN] = trc_en_r;
                rd_val[C_CLK] = o_clk_ext_sel;
                rd_val[C_RDY] = rdy_en_r;
                rd_val[C_TON] = trc_on_r;
            end
            A_CAUSE:                    rd_val = 32'(cause_r); // R22
            A_BP0:                      rd_val = 32'(bp_cfg[0]);
            A_BP0 + O_ADR:              rd_val = 32'(bp_adr[0]);
            A_BP0 + O_DAT:              rd_val = bp_dat[0];
            A_BP0 + BP_STRIDE:          rd_val = 32'(bp_cfg[1]);
            A_BP0 + BP_STRIDE + O_ADR:  rd_val = 32'(bp_adr[1]);
            A_BP0 + BP_STRIDE + O_DAT:  rd_val = bp_dat[1];
            A_TP0:                      rd_val = 32'(tp_adr[0]);
            A_TP0 + O_ADR:              rd_val = 32'(tp_cfg[0]);
            A_TP0 + TP_STRIDE:          rd_val = 32'(tp_adr[1]);
            A_TP0 + TP_STRIDE + O_ADR:  rd_val = 32'(tp_cfg[1]);
            A_TPTR:                     rd_val = {6'h00, t_cnt_r, 6'h00, rd_ptr_r};
            A_TDAT:                     rd_val = 32'(trc_mem[rd_ptr_r]);
            default:                    rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_rdata <= 32'h0000_0000;
        else
            o_rdata <= i_rd ? rd_val : 32'h0000_0000;
    end

    property p_bp_stop;
        run && bp_hit != 2'h0 |=> !o_emul && o_brk_match ##1 st_r == ST_IDLE;
    endproperty
    a_bp_stop: assert property (p_bp_stop) else $error("breakpoint did not stop"); // R1

    property p_exec;
        run && g_bp[0].ex_hit |=> cause_r == CZ_BP0;
    endproperty
    a_exec: assert property (p_exec) else $error("exec break cause wrong"); // R3

    property p_ext_once;
        run && !ext_prev_r && !i_brk_ext_n && bp_hit == 2'h0 && !grd_hit && !sw_stop
            |=> o_emul;
    endproperty
    a_ext_once: assert property (p_ext_once) else $error("static low broke"); // R9

    property p_match_pulse;
        o_brk_match |=> !o_brk_match;
    endproperty
    a_match_pulse: assert property (p_match_pulse) else $error("match not a pulse"); // R11

    property p_wrap;
        cap && wr_ptr_r == DMAX |=> wr_ptr_r == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("trace pointer did not wrap"); // R16

    property p_trc_off;
        !trc_en_r |=> wr_ptr_r == $past(wr_ptr_r);
    endproperty
    a_trc_off: assert property (p_trc_off) else $error("capture while disabled"); // R17

    property p_oldest;
        i_wr && i_addr == A_TPTR && i_wdata[1:0] == PO_OLD && t_cnt_r > DMAX && !cap
            |=> rd_ptr_r == $past(wr_ptr_r);
    endproperty
    a_oldest: assert property (p_oldest) else $error("oldest pointer wrong"); // R18

    property p_nmi_gate;
        !run |=> !o_nmi && !o_reset && o_hold == $past(i_hold);
    endproperty
    a_nmi_gate: assert property (p_nmi_gate) else $error("nmi or reset leaked"); // R20

    property p_rdy;
        lat_mk_r == MK_BORROW && !rdy_en_r |=> o_rdy;
    endproperty
    a_rdy: assert property (p_rdy) else $error("borrowed ready not forced"); // R21

    property p_guard;
        run && grd_hit && bp_hit == 2'h0 && !ext_fall |=> cause_r == CZ_GRD ##1 !o_emul;
    endproperty
    a_guard: assert property (p_guard) else $error("guarded access missed"); // R24
endmodule

// File: bench/btu_target_model.sv
// target cpu model: drives multiplexed address/data, status, segment and queue pins
// assumes the caller enters bus_cycle right after a rising clock edge
`timescale 1ns/10ps
module btu_target_model
    import btu_pkg::*;
(
    input  wire logic        i_clk_sys,
    output logic      [19:0] o_ad,
    output logic             o_ale,
    output logic             o_dv,
    output logic      [2:0]  o_stat,
    output logic      [1:0]  o_seg,
    output logic      [1:0]  o_qs
);
    initial
    begin
        o_ad = 20'h0_0000;
        o_ale = 1'b0;
        o_dv = 1'b0;
        o_stat = BS_PASS;
        o_seg = 2'h0;
        o_qs = QS_NONE;
    end

    // address phase then data phase; released lines show the inverse of the last value
    task automatic bus_cycle(input logic [2:0] st, input logic [1:0] sg,
                             input logic [19:0] a, input logic [15:0] d);
        o_ale <= 1'b1;
        o_ad <= a;
        o_stat <= st;
        o_seg <= sg;
        @(posedge i_clk_sys);
        o_ale <= 1'b0;
        o_dv <= 1'b1;
        o_ad <= {~a[19:16], d};
        @(posedge i_clk_sys);
        o_dv <= 1'b0;
        o_ad <= {a[19:16], ~d};
        o_stat <= BS_PASS;
        @(posedge i_clk_sys);
    endtask

    task automatic queue_op(input logic [1:0] q);
        o_qs <= q;
        @(posedge i_clk_sys);
        o_qs <= QS_NONE;
    endtask
endmodule

// File: bench/testbench.sv
// self-checking bench: register port tasks, target model, reference trace queue
// assumes btu_top at default depth and the target model on its bus pins
`timescale 1ns/10ps
module testbench;
    import btu_pkg::*;
    logic        i_clk_sys, i_rstn, i_wr, i_rd, i_ale, i_dv, i_brk_ext_n, i_nmi, i_reset;
    logic        i_rdy, i_request_grant_line, i_hold, o_emul, o_brk_match, o_clk_ext_sel;
    logic        o_nmi, o_reset, o_rdy, o_request_grant_line, o_hold, tron;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, seed, rd;
    logic [19:0] i_ad;
    logic [2:0]  i_stat;
    logic [1:0]  i_seg, i_qs;
    logic [28:0] frames[$];
    int          failures, comparisons, cycles, brk_cnt, brks;

    btu_top u_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ad(i_ad),
        .i_ale(i_ale), .i_dv(i_dv), .i_stat(i_stat), .i_seg(i_seg), .i_qs(i_qs),
        .i_brk_ext_n(i_brk_ext_n), .i_nmi(i_nmi), .i_reset(i_reset), .i_rdy(i_rdy),
        .i_request_grant_line(i_request_grant_line), .i_hold(i_hold), .o_emul(o_emul),
        .o_brk_match(o_brk_match), .o_clk_ext_sel(o_clk_ext_sel), .o_nmi(o_nmi),
        .o_reset(o_reset), .o_rdy(o_rdy), .o_request_grant_line(o_request_grant_line),
        .o_hold(o_hold));
    btu_target_model u_tgt (.i_clk_sys(i_clk_sys), .o_ad(i_ad), .o_ale(i_ale),
        .o_dv(i_dv), .o_stat(i_stat), .o_seg(i_seg), .o_qs(i_qs));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // pulses are counted at the edge so a one-cycle pulse inside a bus cycle is not missed
    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (o_brk_match === 1'b1)
            brk_cnt <= brk_cnt + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: pin %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic rd_get(input logic [7:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 rd = o_rdata;
        @(posedge i_clk_sys);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd_get(a);
        chk_reg(rd, exp);
    endtask

    task automatic go(input logic [31:0] ctrl);
        wr(A_CTRL, ctrl);
        #1 chk_pin(o_emul, 1'b1);
        chk_pin(o_nmi, 1'b1);
        chk_pin(o_reset, 1'b1);
        chk_pin(o_clk_ext_sel, ctrl[C_CLK]);
        @(posedge i_clk_sys);
    endtask

    task automatic cyc(input logic [2:0] st, input logic [19:0] a, input logic [15:0] d);
        logic [31:0] r;
        r = rnd();
        u_tgt.bus_cycle(st, r[1:0], a, d);
        if (tron)
        begin
            frames.push_back({1'b0, 1'b1, r[1:0], 2'b00, st, a});
            frames.push_back({1'b1, 1'b0, r[1:0], 2'b00, st, ~a[19:16], d});
        end
        while (frames.size() > 1023)
            void'(frames.pop_front());
    endtask

    task automatic wait_brk(input logic [2:0] cz);
        int n;
        n = 0;
        #1;
        while (o_emul !== 1'b0 && n < 16)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk_pin(o_emul, 1'b0);
        repeat (2) @(posedge i_clk_sys);
        chk_reg(brk_cnt, brks + 1);
        brks = brk_cnt;
        rd_chk(A_CAUSE, {29'h0, cz});
    endtask

    initial
    begin
        {i_wr, i_rd, i_addr, i_wdata, failures, comparisons, cycles, brk_cnt, brks} = '0;
        {i_rstn, tron} = 2'b00;
        {i_brk_ext_n, i_nmi, i_reset, i_rdy, i_request_grant_line, i_hold} = 6'h3f;
        seed = 32'h68f1_5dc5;
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        rd_chk(A_CTRL, 32'h0000_0014);
        rd_chk(A_CAUSE, 32'h0000_0000);
        rd_chk(8'h3c, 32'h0000_0000);
        #1 chk_pin(o_nmi, 1'b0);
        chk_pin(o_hold, 1'b1);
        chk_pin(o_request_grant_line, 1'b1);
        @(posedge i_clk_sys);
        wr(A_MAP, 32'h0001_0001);
        wr(A_BP0, 32'h0000_4081);
        wr(A_BP0 + O_ADR, 32'h0000_0456);
        wr(A_BP0 + O_DAT, 32'h0000_a5c3 | 32'hffff_0000);
        go(32'h0000_0015);
        cyc(BS_MRD, 20'h0_0456, 16'ha5c3);
        cyc(BS_MWR, 20'h0_0456, 16'ha5c2);
        cyc(BS_MWR, 20'h0_0457, 16'ha5c3);
        #1 chk_pin(o_emul, 1'b1);
        @(posedge i_clk_sys);
        cyc(BS_MWR, 20'h0_0456, 16'ha5c3);
        wait_brk(CZ_BP0);
        go(32'h0000_0015);
        rd_chk(A_CAUSE, 32'h0000_0000);
        i_brk_ext_n <= 1'b0;
        wait_brk(CZ_EXT);
        go(32'h0000_0015);
        repeat (20) @(posedge i_clk_sys);
        chk_reg(brk_cnt, brks);
        #1 chk_pin(o_emul, 1'b1);
        @(posedge i_clk_sys);
        wr(A_CTRL, 32'h0000_0016);
        rd_chk(A_CAUSE, {29'h0, CZ_SW});
        brks = brk_cnt;
        i_brk_ext_n <= 1'b1;
        go(32'h0000_001d);
        cyc(BS_MRD, 20'h0_1400 | 20'(rnd() & 32'h3ff), 16'h0000);
        wait_brk(CZ_GRD);
        wr(A_BP0 + BP_STRIDE, 32'h0000_2041);
        wr(A_BP0 + BP_STRIDE + O_ADR, 32'h0000_0700);
        go(32'h0000_0015);
        cyc(BS_MRD, 20'h0_06ff, 16'h1234);
        cyc(BS_MRD, 20'h0_0700, 16'h1234);
        wait_brk(CZ_BP1);
        wr(A_BP0, 32'h0000_0003);
        go(32'h0000_0015);
        cyc(BS_FETCH, 20'h0_0456, 16'h0000);
        #1 chk_pin(o_emul, 1'b1);
        u_tgt.queue_op(QS_FIRST);
        wait_brk(CZ_BP0);
        wr(A_MAP, 32'h0002_0002);
        wr(A_CTRL, 32'h0000_0004);
        i_rdy <= 1'b0;
        u_tgt.bus_cycle(BS_MRD, 2'h0, 20'h0_0800, 16'h0000);
        #1 chk_pin(o_rdy, 1'b1);
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        wr(A_MAP, 32'h0001_0001);
        go(32'h0000_0011);
        repeat (4) cyc(BS_MRD, 20'h0_0400 | 20'(rnd() & 32'h3ff), 16'h5555);
        wr(A_CTRL, 32'h0000_0012);
        rd_get(A_TPTR);
        chk_reg({22'h0, rd[25:16]}, 32'h0);
        go(32'h0000_0015);
        tron = 1'b1;
        repeat (520) cyc(BS_MRD, 20'h0_0400 | 20'(rnd() & 32'h3ff), 16'(rnd() >> 16));
        wr(A_CTRL, 32'h0000_0016);
        rd_get(A_TPTR);
        chk_reg({22'h0, rd[25:16]}, frames.size());
        wr(A_TPTR, {30'h0, PO_NEW});
        rd_chk(A_TDAT, {3'h0, frames[$]});
        wr(A_TPTR, {6'h0, 10'd1, 14'h0, PO_BACK});
        rd_chk(A_TDAT, {3'h0, frames[$-1]});
        wr(A_TPTR, {30'h0, PO_OLD});
        rd_chk(A_TDAT, {3'h0, frames[0]});
        wr(A_TPTR, {6'h0, 10'd2, 14'h0, PO_FWD});
        rd_chk(A_TDAT, {3'h0, frames[2]});
        stop_test();
    end
endmodule
